/* src/fcw_cfg_regs.v */
/*
 * Configuration register block of a serial NOR flash: erase/reset options,
 * burst wrap boot and live settings, a serial command slave serving the
 * generic register read/write, set burst length and software reset
 * commands, the blank-check erase decision and the page buffer wrap.
 * Assumes SPI mode 0 from a host whose clock is far slower than ref_clk
 * (at least four ref_clk periods per half period); erase engine, page
 * buffer and read datapath sit outside and use the strobes below.
 */
`timescale 1ns/1ps
`include "fcw_consts.vh"

// Functional notes
// - Registers are read with command 65h and written with command 71h.
// - Live blank-check enable loads from its boot copy at every reset.
// - Blank check on: erase unconditionally when previous erase failed.
// - Previous erase good: scan, erase on first zero, else skip.
// - Blank check covers parameter, sector and bulk erase.
// - Blank check off: every erase starts unconditionally.
// - Page wrap bit: 1 wraps at 512 bytes, 0 at 256 bytes.
// - In 256 mode loads past 255 restart at buffer address zero.
// - Param-sector bit 1 gives uniform sectors, 0 keeps 4 KB sectors.
// - Live param-sector bit is read-only, follows its boot copy.
// - F0h resets only when legacy reset enable is 1.
// - 66h then 99h always performs a software reset.
// - Burst wrap applies to main array reads only.
// - Every reset copies the boot wrap settings into the live copy.
// - Set burst length C0h also writes the live wrap settings.
// - Wrap bit 0 enables wrap, 1 disables; boot default is 1.
// - Wrap applies only to quad I/O and DDR quad I/O reads.
// - Wrap length 00/01/10/11 gives 8/16/32/64 bytes; default 00.
// - Drive strength code sits in bits 7 to 5, default 000.
module fcw_cfg_regs (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset_n,
    // Serial link pins
    input  wire        sck,
    input  wire        cs_n,
    input  wire        si,
    output wire        so,
    output wire        so_oe_n,
    // Erase engine handshake
    input  wire        erase_req,
    input  wire [1:0]  erase_kind,
    input  wire        erase_prev_ok,
    input  wire        scan_zero_found,
    input  wire        scan_done,
    output wire        scan_start,
    output wire        erase_start,
    output wire        erase_skip,
    // Page buffer load address
    input  wire        pbuf_load,
    input  wire [8:0]  pbuf_addr_in,
    output wire [8:0]  pbuf_addr,
    // Read path and configuration outputs
    input  wire [1:0]  rd_kind,
    input  wire        rd_main_array,
    output wire        burst_wrap_active,
    output wire [6:0]  burst_wrap_bytes,
    output wire [2:0]  drive_strength_code,
    output wire        param_sector_disable,
    output wire        sw_reset_pulse
);

    // Erase decision states
    localparam ST_IDLE = 1'b0;
    localparam ST_SCAN = 1'b1;

    // Register contents
    reg [7:0]  erase_option_boot_copy_q;
    reg [7:0]  erase_and_reset_option_control_q;
    reg [7:0]  burst_wrap_boot_settings_q;
    reg [7:0]  burst_wrap_live_settings_q;

    // Link synchronisers and frame state
    reg        sck_s1_q, sck_s2_q, sck_s3_q;
    reg        cs_s1_q, cs_s2_q, cs_s3_q;
    reg        si_s1_q, si_s2_q;
    reg [2:0]  bit_cnt_q;
    reg [2:0]  byte_cnt_q;
    reg [7:0]  shift_q;
    reg [7:0]  cmd_q;
    reg [23:0] addr_q;
    reg        so_q;
    reg        so_drive_q;
    reg        reset_armed_q;
    reg        sw_reset_q;

    // Erase and datapath outputs
    reg        erase_st_q;
    reg        scan_start_q;
    reg        erase_start_q;
    reg        erase_skip_q;
    reg [8:0]  pbuf_addr_q;
    reg        wrap_active_q;

    wire       sck_rise  = sck_s2_q & ~sck_s3_q;
    wire       sck_fall  = ~sck_s2_q & sck_s3_q;
    wire       cs_active = ~cs_s2_q;
    wire       cs_end    = cs_s2_q & ~cs_s3_q;
    wire [7:0] byte_in   = {shift_q[6:0], si_s2_q};
    wire [7:0] rd_byte   = reg_read(addr_q);

    // Register readback by address; unmapped addresses read zero
    function [7:0] reg_read;
        input [23:0] a;
        begin
            case (a)
                `FCW_ADDR_ERASE_BOOT: reg_read = erase_option_boot_copy_q;
                `FCW_ADDR_ERASE_LIVE: reg_read = erase_and_reset_option_control_q;
                `FCW_ADDR_WRAP_BOOT:  reg_read = burst_wrap_boot_settings_q;
                `FCW_ADDR_WRAP_LIVE:  reg_read = burst_wrap_live_settings_q;
                default:              reg_read = 8'h00;
            endcase
        end
    endfunction

    // Pin synchronisers: first stage feeds only the second
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            si_s1_q  <= 1'b0;
            si_s2_q  <= 1'b0;
        end else begin
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            cs_s1_q  <= cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            si_s1_q  <= si;
            si_s2_q  <= si_s1_q;
        end
    end

    // Serial slave and register file; host write bits beyond masks drop
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q     <= 3'h0;
            byte_cnt_q    <= 3'h0;
            shift_q       <= 8'h00;
            cmd_q         <= 8'h00;
            addr_q        <= 24'h000000;
            so_q          <= 1'b0;
            so_drive_q    <= 1'b0;
            reset_armed_q <= 1'b0;
            sw_reset_q    <= 1'b0;
            // power-on loads live copies from boot copies
            erase_option_boot_copy_q         <= `FCW_RST_ERASE_BOOT;
            erase_and_reset_option_control_q <= `FCW_RST_ERASE_BOOT;
            burst_wrap_boot_settings_q       <= `FCW_RST_WRAP_BOOT;
            burst_wrap_live_settings_q       <= `FCW_RST_WRAP_BOOT;
        end else begin
            sw_reset_q <= 1'b0;
            if (!cs_active) begin
                bit_cnt_q  <= 3'h0;
                byte_cnt_q <= 3'h0;
                so_drive_q <= 1'b0;
            end
            if (cs_active && sck_rise) begin
                shift_q   <= byte_in;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    if (byte_cnt_q != 3'h7)
                        byte_cnt_q <= byte_cnt_q + 3'h1;
                    if (byte_cnt_q == 3'h0)
                        cmd_q <= byte_in;
                    else if (byte_cnt_q <= 3'h3 && (cmd_q == `FCW_CMD_REG_READ || cmd_q == `FCW_CMD_REG_WRITE))
                        addr_q <= {addr_q[15:0], byte_in};
                    // generic write of the addressed register
                    if (byte_cnt_q == 3'h4 && cmd_q == `FCW_CMD_REG_WRITE) begin
                        case (addr_q)
                            `FCW_ADDR_ERASE_BOOT: begin
                                // boot bits program one way; param bit mirrors to live
                                erase_option_boot_copy_q <= erase_option_boot_copy_q |
                                                            (byte_in & `FCW_MASK_ERASE);
                                erase_and_reset_option_control_q[`FCW_BIT_PARAM_DIS] <=
                                    erase_option_boot_copy_q[`FCW_BIT_PARAM_DIS] | byte_in[`FCW_BIT_PARAM_DIS];
                            end
                            `FCW_ADDR_ERASE_LIVE: begin
                                erase_and_reset_option_control_q <=
                                    (byte_in & `FCW_MASK_ERASE_LIVE_W) |
                                    (erase_and_reset_option_control_q & ~`FCW_MASK_ERASE_LIVE_W);
                            end
                            `FCW_ADDR_WRAP_BOOT: burst_wrap_boot_settings_q <= byte_in & `FCW_MASK_WRAP;
                            `FCW_ADDR_WRAP_LIVE: burst_wrap_live_settings_q <= byte_in & `FCW_MASK_WRAP;
                            default: ;
                        endcase
                    end
                    // set burst length writes live wrap settings
                    if (byte_cnt_q == 3'h1 && cmd_q == `FCW_CMD_SET_BURST)
                        burst_wrap_live_settings_q <= byte_in & `FCW_MASK_WRAP;
                    // Read data phase starts after the third address byte
                    if (byte_cnt_q == 3'h3 && cmd_q == `FCW_CMD_REG_READ)
                        so_drive_q <= 1'b1;
                end
            end
            // Shift read data on falling edges, MSB first, repeating
            if (cs_active && sck_fall && so_drive_q)
                so_q <= rd_byte[3'h7 - bit_cnt_q];
            // Single-byte commands act at frame end
            if (cs_end) begin
                if (byte_cnt_q == 3'h1 && bit_cnt_q == 3'h0) begin
                    // reset enable must be the frame just before
                    reset_armed_q <= (cmd_q == `FCW_CMD_RESET_ENABLE);
                    // legacy reset gated, two-step reset always
                    if ((cmd_q == `FCW_CMD_LEGACY_RESET &&
                         erase_and_reset_option_control_q[`FCW_BIT_LEGACY_RST]) ||
                        (cmd_q == `FCW_CMD_RESET_DO && reset_armed_q)) begin
                        sw_reset_q <= 1'b1;
                        erase_and_reset_option_control_q <= erase_option_boot_copy_q;
                        burst_wrap_live_settings_q       <= burst_wrap_boot_settings_q;
                    end
                end else begin
                    reset_armed_q <= 1'b0;
                end
            end
        end
    end

    // Blank-check erase decision
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            erase_st_q    <= ST_IDLE;
            scan_start_q  <= 1'b0;
            erase_start_q <= 1'b0;
            erase_skip_q  <= 1'b0;
        end else begin
            scan_start_q  <= 1'b0;
            erase_start_q <= 1'b0;
            erase_skip_q  <= 1'b0;
            case (erase_st_q)
                ST_IDLE: begin
                    // all three erase kinds treated alike
                    if (erase_req && (erase_kind == `FCW_ERASE_PARAM || erase_kind == `FCW_ERASE_SECTOR ||
                                      erase_kind == `FCW_ERASE_BULK)) begin
                        if (!erase_and_reset_option_control_q[`FCW_BIT_BLANK_CHECK] || !erase_prev_ok) begin
                            erase_start_q <= 1'b1;
                        end else begin
                            scan_start_q <= 1'b1;
                            erase_st_q   <= ST_SCAN;
                        end
                    end
                end
                ST_SCAN: begin
                    // erase on first zero, skip when blank
                    if (scan_zero_found) begin
                        erase_start_q <= 1'b1;
                        erase_st_q    <= ST_IDLE;
                    end else if (scan_done) begin
                        erase_skip_q <= 1'b1;
                        erase_st_q   <= ST_IDLE;
                    end
                end
                default: erase_st_q <= ST_IDLE;
            endcase
        end
    end

    // Page buffer address and read wrap qualification
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pbuf_addr_q   <= 9'h000;
            wrap_active_q <= 1'b0;
        end else begin
            // 256-byte mode drops the top address bit
            if (pbuf_load)
                pbuf_addr_q <= erase_and_reset_option_control_q[`FCW_BIT_PAGE_WRAP] ?
                               pbuf_addr_in : {1'b0, pbuf_addr_in[7:0]};
            // wrap only for main-array quad reads
            wrap_active_q <= ~burst_wrap_live_settings_q[`FCW_BIT_WRAP_OFF] & rd_main_array &
                             (rd_kind == `FCW_RD_QUAD_IO || rd_kind == `FCW_RD_DDR_QUAD_IO);
        end
    end

    // Outputs
    assign so                   = so_q;
    assign so_oe_n              = ~(so_drive_q & cs_active);
    assign scan_start           = scan_start_q;
    assign erase_start          = erase_start_q;
    assign erase_skip           = erase_skip_q;
    assign pbuf_addr            = pbuf_addr_q;
    assign burst_wrap_active    = wrap_active_q;
    // wrap length 8 shifted by the code
    assign burst_wrap_bytes     = 7'h08 << burst_wrap_live_settings_q[`FCW_BIT_WLEN_HI:`FCW_BIT_WLEN_LO];
    // drive strength from the live copy
    assign drive_strength_code  = burst_wrap_live_settings_q[`FCW_BIT_DRIVE_HI:`FCW_BIT_DRIVE_LO];
    assign param_sector_disable = erase_and_reset_option_control_q[`FCW_BIT_PARAM_DIS];
    assign sw_reset_pulse       = sw_reset_q;

endmodule

/* src/fcw_consts.vh */
/*
 * Constants for the flash configuration register block: command codes,
 * register addresses, field positions, write masks and reset values.
 * Assumes it is included by bare name from the design files under src/.
 */
`ifndef FCW_CONSTS_VH
`define FCW_CONSTS_VH

// Command opcodes
`define FCW_CMD_REG_READ      8'h65
`define FCW_CMD_REG_WRITE     8'h71
`define FCW_CMD_SET_BURST     8'hC0
`define FCW_CMD_LEGACY_RESET  8'hF0
`define FCW_CMD_RESET_ENABLE  8'h66
`define FCW_CMD_RESET_DO      8'h99

// Register addresses on the 24-bit address phase
`define FCW_ADDR_ERASE_BOOT   24'h000010
`define FCW_ADDR_ERASE_LIVE   24'h000011
`define FCW_ADDR_WRAP_BOOT    24'h000020
`define FCW_ADDR_WRAP_LIVE    24'h000021

// Erase and reset option field positions
`define FCW_BIT_BLANK_CHECK   5
`define FCW_BIT_PAGE_WRAP     4
`define FCW_BIT_PARAM_DIS     3
`define FCW_BIT_LEGACY_RST    0

// Burst wrap field positions
`define FCW_BIT_DRIVE_HI      7
`define FCW_BIT_DRIVE_LO      5
`define FCW_BIT_WRAP_OFF      4
`define FCW_BIT_WLEN_HI       1
`define FCW_BIT_WLEN_LO       0

// Write masks; bits outside the ERASE and WRAP masks read zero
`define FCW_MASK_ERASE        8'h39
`define FCW_MASK_ERASE_LIVE_W 8'h31
`define FCW_MASK_WRAP         8'hF3

// Boot-copy reset values
`define FCW_RST_ERASE_BOOT    8'h00
`define FCW_RST_WRAP_BOOT     8'h10

// Erase kinds
`define FCW_ERASE_PARAM       2'h0
`define FCW_ERASE_SECTOR      2'h1
`define FCW_ERASE_BULK        2'h2

// Read kinds
`define FCW_RD_QUAD_IO        2'h1
`define FCW_RD_DDR_QUAD_IO    2'h2

// Page buffer
`define FCW_PBUF_AW           9

`endif

/* sim/fcw_host_model.sv */
/*
 * Host-side serial controller model: mode 0 frames, bits MSB first.
 * Assumes ref_clk at 100 MHz; the link clock is paced at 80 ns from it.
 */
`timescale 1ns/1ps
module fcw_host_model (
    // Clock
    input  wire       ref_clk,
    // Serial link
    output reg        sck,
    output reg        cs_n,
    output reg        si,
    input  wire       so
);
    reg  [39:0] rx_q;

    // Idle levels; sck stands still low outside frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_q = 40'h0;
    end

    // Four ref_clk per half period gives the 80 ns link clock
    task half;
        repeat (4) @(negedge ref_clk);
    endtask

    task xfer(input [39:0] tx, input integer nb, output [7:0] rx);
        integer i;
        begin
            cs_n = 1'b0;
            half;
            for (i = nb - 1; i >= 0; i = i - 1) begin
                si = tx[i];
                half;
                sck = 1'b1;
                rx_q = {rx_q[38:0], so};
                half;
                sck = 1'b0;
            end
            half;
            cs_n = 1'b1;
            si = ~si; // Released line must not keep its last value
            rx = rx_q[7:0];
            repeat (8) @(negedge ref_clk);
        end
    endtask
endmodule

/* sim/fcw_cfg_asserts.sv */
/*
 * Port-level checker for the configuration register block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module fcw_cfg_asserts (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       reset_n,
    input  wire       cs_n,
    // Erase engine
    input  wire       erase_req,
    input  wire [1:0] erase_kind,
    input  wire       erase_prev_ok,
    input  wire       scan_zero_found,
    input  wire       scan_done,
    input  wire       scan_start,
    input  wire       erase_start,
    input  wire       erase_skip,
    // Buffer, read path, options
    input  wire       pbuf_load,
    input  wire [8:0] pbuf_addr_in,
    input  wire [8:0] pbuf_addr,
    input  wire [1:0] rd_kind,
    input  wire       rd_main_array,
    input  wire       burst_wrap_active,
    input  wire [6:0] burst_wrap_bytes,
    input  wire       param_sector_disable,
    input  wire       sw_reset_pulse
);
    reg scan_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Open blank scan, so its outcome can be tied to the result
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            scan_q <= 1'b0;
        else if (scan_start)
            scan_q <= 1'b1;
        else if (erase_start || erase_skip)
            scan_q <= 1'b0;
    end

    property p_prev_bad;
        erase_req && !erase_prev_ok && erase_kind != 2'h3 |=> erase_start && !scan_start;
    endproperty
    a_prev_bad: assert property (p_prev_bad) else $error("failed erase not redone");
    property p_zero;
        scan_q && scan_zero_found |=> erase_start && !erase_skip;
    endproperty
    a_zero: assert property (p_zero) else $error("zero found but no erase");
    property p_blank;
        scan_q && scan_done && !scan_zero_found |=> erase_skip && !erase_start;
    endproperty
    a_blank: assert property (p_blank) else $error("blank sector not skipped");
    property p_kinds;
        erase_req && erase_kind != 2'h3 |=> erase_start ^ scan_start;
    endproperty
    a_kinds: assert property (p_kinds) else $error("erase request not answered");
    property p_pbuf;
        pbuf_load |=> pbuf_addr[7:0] == $past(pbuf_addr_in[7:0]) && (!pbuf_addr[8] || $past(pbuf_addr_in[8]));
    endproperty
    a_pbuf: assert property (p_pbuf) else $error("buffer address mapped wrongly");
    property p_wrap_kind;
        burst_wrap_active |-> $past(rd_main_array) && ($past(rd_kind) == 2'h1 || $past(rd_kind) == 2'h2);
    endproperty
    a_wrap_kind: assert property (p_wrap_kind) else $error("wrap on wrong read");
    property p_wlen;
        (burst_wrap_bytes == 7'h08 || burst_wrap_bytes == 7'h10 || burst_wrap_bytes == 7'h20 || burst_wrap_bytes == 7'h40)
            && (!$changed(burst_wrap_bytes) || !cs_n || sw_reset_pulse);
    endproperty
    a_wlen: assert property (p_wlen) else $error("bad wrap length or change outside frame");
    property p_param;
        !$fell(param_sector_disable);
    endproperty
    a_param: assert property (p_param) else $error("sector map bit cleared");
    property p_swr;
        sw_reset_pulse |-> cs_n ##1 !sw_reset_pulse;
    endproperty
    a_swr: assert property (p_swr) else $error("reset pulse mid frame or long");
endmodule

bind fcw_cfg_regs fcw_cfg_asserts chk_u (.ref_clk, .reset_n, .cs_n, .erase_req, .erase_kind, .erase_prev_ok,
    .scan_zero_found, .scan_done, .scan_start, .erase_start, .erase_skip, .pbuf_load, .pbuf_addr_in, .pbuf_addr,
    .rd_kind, .rd_main_array, .burst_wrap_active, .burst_wrap_bytes, .param_sector_disable, .sw_reset_pulse);

/* sim/tb_top.sv */
/*
 * Self-checking bench for the configuration register block.
 * Assumes the host model paces the link; the bench plays erase engine,
 * page buffer and read path.
 */
`timescale 1ns/1ps
`include "fcw_consts.vh"
module tb_top;
    reg        ref_clk = 1'b0;
    reg        reset_n = 1'b0;
    reg        erase_req = 1'b0;
    reg  [1:0] erase_kind = 2'h0;
    reg        erase_prev_ok = 1'b0;
    reg        scan_zero_found = 1'b0;
    reg        scan_done = 1'b0;
    reg        pbuf_load = 1'b0;
    reg  [8:0] pbuf_addr_in = 9'h000;
    reg  [1:0] rd_kind = 2'h0;
    reg        rd_main_array = 1'b0;
    wire       sck, cs_n, si, so, so_oe_n, scan_start, erase_start, erase_skip;
    // Line with no pull: when the block lets go, the host sees the inverse of the last level
    wire       so_line = so_oe_n ? ~so : so;
    wire       burst_wrap_active, param_sector_disable, sw_reset_pulse;
    wire [8:0] pbuf_addr;
    wire [6:0] burst_wrap_bytes;
    wire [2:0] drive_strength_code;
    integer    fails = 0, num_checks = 0, resets = 0, cycles = 0, k;
    reg  [7:0] rd;

    fcw_cfg_regs dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe_n(so_oe_n), .erase_req(erase_req), .erase_kind(erase_kind), .erase_prev_ok(erase_prev_ok),
        .scan_zero_found(scan_zero_found), .scan_done(scan_done), .scan_start(scan_start),
        .erase_start(erase_start), .erase_skip(erase_skip), .pbuf_load(pbuf_load), .pbuf_addr_in(pbuf_addr_in),
        .pbuf_addr(pbuf_addr), .rd_kind(rd_kind), .rd_main_array(rd_main_array),
        .burst_wrap_active(burst_wrap_active), .burst_wrap_bytes(burst_wrap_bytes),
        .drive_strength_code(drive_strength_code), .param_sector_disable(param_sector_disable),
        .sw_reset_pulse(sw_reset_pulse));
    fcw_host_model host_u (.ref_clk(ref_clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

    // Clock at 100 MHz
    always #5 ref_clk = ~ref_clk;
    // Reset pulses are counted; the cycle ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (sw_reset_pulse === 1'b1) resets = resets + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            print_verdict;
        end
    end

    task chk(input string nm, input [8:0] seen, input [8:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task rreg(input [23:0] a, input [7:0] e);
        host_u.xfer({`FCW_CMD_REG_READ, a, 8'h00}, 40, rd);
        chk("register read", rd, e);
        chk("so_oe_n", so_oe_n, 9'h1);
    endtask
    task wreg(input [23:0] a, input [7:0] d);
        host_u.xfer({`FCW_CMD_REG_WRITE, a, d}, 40, rd);
    endtask
    task cmd(input [7:0] c);
        host_u.xfer({32'h0, c}, 8, rd);
    endtask
    task erq(input [1:0] kd, input ok);
        @(negedge ref_clk);
        {erase_req, erase_kind, erase_prev_ok} = {1'b1, kd, ok};
        @(negedge ref_clk);
        erase_req = 1'b0;
    endtask
    task pb(input [8:0] a, input [8:0] e);
        @(negedge ref_clk);
        {pbuf_load, pbuf_addr_in} = {1'b1, a};
        @(negedge ref_clk);
        pbuf_load = 1'b0;
        chk("pbuf_addr", pbuf_addr, e);
    endtask

    // Boot values after power-on, unmapped place reads zero
    task t_defaults;
        chk("drive", drive_strength_code, 9'h0);
        chk("wrap bytes", burst_wrap_bytes, 9'h8);
        rreg(`FCW_ADDR_WRAP_LIVE, 8'h10);
        rreg(`FCW_ADDR_WRAP_BOOT, 8'h10);
        rreg(`FCW_ADDR_ERASE_LIVE, 8'h00);
        rreg(24'h000030, 8'h00);
    endtask
    // Generic write with reserved bits, then every length by set burst length
    task t_wrap;
        wreg(`FCW_ADDR_WRAP_LIVE, 8'h5A);
        rreg(`FCW_ADDR_WRAP_LIVE, 8'h52);
        chk("drive", drive_strength_code, 9'h2);
        for (k = 0; k < 4; k = k + 1) begin
            host_u.xfer({24'h0, `FCW_CMD_SET_BURST, 6'h38, k[1:0]}, 16, rd);
            chk("wrap bytes", burst_wrap_bytes, 9'h8 << k);
        end
        chk("drive", drive_strength_code, 9'h7);
    endtask
    // Wrap only on quad kinds of the main array, and only with wrap on
    task t_burst;
        for (k = 0; k < 9; k = k + 1) begin
            if (k == 8) host_u.xfer({24'h0, `FCW_CMD_SET_BURST, 8'h10}, 16, rd);
            @(negedge ref_clk);
            {rd_main_array, rd_kind} = (k == 8) ? 3'h5 : k[2:0];
            @(negedge ref_clk);
            chk("wrap active", burst_wrap_active, k < 8 && k[2] && (k[1:0] == 2'h1 || k[1:0] == 2'h2));
        end
    endtask
    // Blank-check decisions for every erase kind, then check turned off
    task t_erase;
        // live sector map bit written equal to its boot copy
        wreg(`FCW_ADDR_ERASE_LIVE, 8'hF7);
        rreg(`FCW_ADDR_ERASE_LIVE, 8'h31);
        for (k = 0; k < 3; k = k + 1) begin
            erq(k[1:0], 1'b0);
            chk("erase_start", {erase_start, scan_start}, 9'h2);
            erq(k[1:0], 1'b1);
            chk("scan_start", {erase_start, scan_start}, 9'h1);
            @(negedge ref_clk) scan_zero_found = 1'b1;
            @(negedge ref_clk) scan_zero_found = 1'b0;
            chk("erase_start", {erase_start, erase_skip}, 9'h2);
            erq(k[1:0], 1'b1);
            @(negedge ref_clk) scan_done = 1'b1;
            @(negedge ref_clk) scan_done = 1'b0;
            chk("erase_skip", {erase_start, erase_skip}, 9'h1);
        end
        erq(2'h3, 1'b0);
        chk("erase_start", {erase_start, scan_start}, 9'h0);
        pb(9'h1FF, 9'h1FF);
        // Live options cleared: 256-byte wrap, blank check and legacy reset off
        wreg(`FCW_ADDR_ERASE_LIVE, 8'h00);
        pb(9'h1FF, 9'h0FF);
        erq(`FCW_ERASE_BULK, 1'b1);
        chk("erase_start", {erase_start, scan_start}, 9'h2);
    endtask
    // Legacy and two-frame software resets, reload from boot copies
    task t_reset;
        cmd(`FCW_CMD_LEGACY_RESET);
        chk("reset count", resets, 9'h0);
        wreg(`FCW_ADDR_ERASE_LIVE, 8'h01);
        cmd(`FCW_CMD_LEGACY_RESET);
        chk("reset count", resets, 9'h1);
        cmd(`FCW_CMD_RESET_DO);
        chk("reset count", resets, 9'h1);
        wreg(`FCW_ADDR_ERASE_BOOT, 8'h28);
        chk("sector map", param_sector_disable, 9'h1);
        wreg(`FCW_ADDR_WRAP_BOOT, 8'h47);
        cmd(`FCW_CMD_RESET_ENABLE);
        cmd(`FCW_CMD_RESET_DO);
        chk("reset count", resets, 9'h2);
        rreg(`FCW_ADDR_WRAP_LIVE, 8'h43);
        rreg(`FCW_ADDR_ERASE_LIVE, 8'h28);
        chk("wrap bytes", burst_wrap_bytes, 9'h40);
    endtask

    task print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_defaults;
        t_wrap;
        t_burst;
        t_erase;
        t_reset;
        print_verdict;
    end
endmodule
